// ===== hw/lcair_regs.sv
/*
 * eight-channel alarm interrupt enable and status registers with change
 * events, sticky event flags and one level interrupt.
 * assumes alarm inputs arrive asynchronously from the line side and the
 * register port is driven on mclk by a single master.
 */
`timescale 1ns/1ps
`default_nettype none

module lcair_regs
    import lcair_pkg::*;
#(
    parameter int unsigned CHANNELS = LCAIR_CHANNELS
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [CHANNELS-1:0] driver_monitor,
    input wire logic [CHANNELS-1:0] fifo_near_limit,
    input wire logic [CHANNELS-1:0] code_violation,
    input wire logic [CHANNELS-1:0] loop_code_event,
    input wire logic [CHANNELS-1:0] alarm_indication_event,
    input wire logic [CHANNELS-1:0] rx_signal_loss_event,
    input wire logic [CHANNELS-1:0] prbs_pattern_event,
    output logic [CHANNELS-1:0][6:0] channel_irq_src,
    output logic irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    lcair_state_s st_q;
    lcair_state_s st_d;
    lcair_bus_s bus;
    logic [2:0] ch_sel;
    logic [3:0] nib_sel;
    logic [CHANNELS-1:0] ch_pend;
    logic [CHANNELS-1:0][2:0] chg;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign ch_sel = bus.addr[LCAIR_CH_MSB:LCAIR_CH_LSB];
    assign nib_sel = bus.addr[3:0];

    // ------------------------------------------------------------
    // per-channel masking and pending terms
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_ch
            assign chg[g] = st_q.s2[g] ^ st_q.live[g];
            // sticky event flags and level sources from other detectors, gated by their enables
            assign channel_irq_src[g][LCAIR_BIT_DRIVER] =
                st_q.evt[g][2] & st_q.en[g][LCAIR_BIT_DRIVER];
            assign channel_irq_src[g][LCAIR_BIT_FIFO] =
                st_q.evt[g][1] & st_q.en[g][LCAIR_BIT_FIFO];
            assign channel_irq_src[g][LCAIR_BIT_CODE] =
                st_q.evt[g][0] & st_q.en[g][LCAIR_BIT_CODE];
            assign channel_irq_src[g][LCAIR_BIT_LOOP] =
                loop_code_event[g] & st_q.en[g][LCAIR_BIT_LOOP];
            assign channel_irq_src[g][LCAIR_BIT_AIS] =
                alarm_indication_event[g] & st_q.en[g][LCAIR_BIT_AIS];
            assign channel_irq_src[g][LCAIR_BIT_LOS] =
                rx_signal_loss_event[g] & st_q.en[g][LCAIR_BIT_LOS];
            assign channel_irq_src[g][LCAIR_BIT_PRBS] =
                prbs_pattern_event[g] & st_q.en[g][LCAIR_BIT_PRBS];
            assign ch_pend[g] = |channel_irq_src[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.rdata = LCAIR_UNMAPPED;
        for (int c = 0; c < CHANNELS; c++) begin
            // two-flop synchronisers; only s2 feeds the logic
            st_d.s1[c] = {driver_monitor[c], fifo_near_limit[c], code_violation[c]};
            st_d.s2[c] = st_q.s1[c];
            st_d.live[c] = st_q.s2[c];
            // clear by writing one, a fresh change wins over the clear
            if (bus.wr && !bus.addr[7] && ch_sel == c[2:0]
                    && nib_sel == LCAIR_OFS_EVENT) begin
                st_d.evt[c] = st_q.evt[c] & ~bus.wdata[6:4];
            end
            // armed blocks a spurious edge on the first sample after reset
            if (st_q.armed) begin
                st_d.evt[c] = st_d.evt[c] | chg[c];
            end
        end
        st_d.armed = 1'b1;
        if (bus.wr && !bus.addr[7] && nib_sel == LCAIR_OFS_IRQ_EN) begin
            st_d.en[ch_sel] = bus.wdata & LCAIR_EN_MASK;
        end
        if (bus.rd) begin
            if (bus.addr == LCAIR_ADDR_IRQ_SUMMARY) begin
                st_d.rdata = 8'(ch_pend);
            end else if (!bus.addr[7]) begin
                unique case (nib_sel)
                    LCAIR_OFS_IRQ_EN: st_d.rdata = st_q.en[ch_sel];
                    LCAIR_OFS_STATUS: st_d.rdata = {1'b0, st_q.live[ch_sel], 4'h0};
                    LCAIR_OFS_EVENT: st_d.rdata = {1'b0, st_q.evt[ch_sel], 4'h0};
                    LCAIR_OFS_GLOBAL: st_d.rdata = {7'h00, |ch_pend};
                    default: st_d.rdata = LCAIR_UNMAPPED;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata = st_q.rdata;
    assign irq = |ch_pend;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // one clock domain, so a default clock and reset cover every property
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // bus terms shared by the properties below
    logic wr_en_hit;
    logic wr_evt_hit;
    logic rd_any_hit;
    assign wr_en_hit = clk_en && reg_wr && !reg_addr[7] && reg_addr[3:0] == LCAIR_OFS_IRQ_EN;
    assign wr_evt_hit = clk_en && reg_wr && !reg_addr[7] && reg_addr[3:0] == LCAIR_OFS_EVENT;
    assign rd_any_hit = clk_en && reg_rd;

    en_write_a: assert property (
        wr_en_hit
        |=> st_q.en[$past(reg_addr[6:4])] == ($past(reg_wdata) & LCAIR_EN_MASK))
        else $error("enable register write not stored");

    driver_gate_a: assert property (
        st_q.evt[0][2] && !st_q.en[0][LCAIR_BIT_DRIVER]
        |-> !channel_irq_src[0][LCAIR_BIT_DRIVER])
        else $error("masked driver event reached interrupt");

    fifo_gate_a: assert property (
        st_q.evt[0][1] && st_q.en[0][LCAIR_BIT_FIFO]
        |-> channel_irq_src[0][LCAIR_BIT_FIFO] && irq)
        else $error("enabled fifo event lost");

    code_gate_a: assert property (
        st_q.evt[0][0] && st_q.en[0][LCAIR_BIT_CODE]
        |-> irq)
        else $error("enabled code event lost");

    loop_gate_a: assert property (
        loop_code_event[0] && st_q.en[0][LCAIR_BIT_LOOP]
        |-> irq)
        else $error("loop event lost");

    ais_gate_a: assert property (
        alarm_indication_event[0] && !st_q.en[0][LCAIR_BIT_AIS]
        |-> !channel_irq_src[0][LCAIR_BIT_AIS])
        else $error("masked ais reached interrupt");

    los_gate_a: assert property (
        rx_signal_loss_event[0] && st_q.en[0][LCAIR_BIT_LOS]
        |-> irq)
        else $error("los event lost");

    prbs_gate_a: assert property (
        prbs_pattern_event[0] && st_q.en[0][LCAIR_BIT_PRBS]
        |-> irq)
        else $error("prbs event lost");

    status_read_a: assert property (
        rd_any_hit && reg_addr == {1'b0, 3'h0, LCAIR_OFS_STATUS}
        |=> reg_rdata == {1'b0, $past(st_q.live[0]), 4'h0})
        else $error("status read mismatch");

    driver_edge_a: assert property (
        clk_en && st_q.armed && $changed(st_q.s2[0][2])
        |=> st_q.evt[0][2])
        else $error("driver change not captured");

    fifo_follow_a: assert property (
        clk_en
        |=> st_q.live[0][1] == $past(st_q.s2[0][1]))
        else $error("fifo status not following");

    fifo_edge_a: assert property (
        clk_en && st_q.armed && chg[1][1]
        |=> st_q.evt[1][1])
        else $error("fifo change not captured");

    code_follow_a: assert property (
        clk_en
        |=> st_q.live[2][0] == $past(st_q.s2[2][0]))
        else $error("code status not following");

    code_edge_a: assert property (
        clk_en && st_q.armed && chg[3][0]
        |=> st_q.evt[3][0])
        else $error("code change not captured");

    decode_read_a: assert property (
        rd_any_hit && reg_addr == {1'b0, 3'h3, LCAIR_OFS_IRQ_EN}
        |=> reg_rdata == $past(st_q.en[3]))
        else $error("channel decode wrong");

    pend_hold_a: assert property (
        st_q.evt[0][2] && !(clk_en && reg_wr)
        |=> st_q.evt[0][2])
        else $error("pending event dropped");

    rdata_idle_a: assert property (
        clk_en && !reg_rd
        |=> reg_rdata == LCAIR_UNMAPPED)
        else $error("read data outside read cycle");

    summary_read_a: assert property (
        rd_any_hit && reg_addr == LCAIR_ADDR_IRQ_SUMMARY
        |=> reg_rdata == 8'($past(ch_pend)))
        else $error("pending summary read wrong");

    global_read_a: assert property (
        rd_any_hit && !reg_addr[7] && reg_addr[3:0] == LCAIR_OFS_GLOBAL
        |=> reg_rdata == {7'h00, $past(irq)})
        else $error("any-pending read wrong");

    armed_set_a: assert property (
        clk_en
        |=> st_q.armed)
        else $error("edge capture not armed");

    // ------------------------------------------------------------
    // per-channel checks
    // ------------------------------------------------------------
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_chk
            // sticky flags: a change sets, only a write of one clears
            ch_drv_on_a: assert property (
                st_q.evt[g][2] && st_q.en[g][LCAIR_BIT_DRIVER]
                |-> channel_irq_src[g][LCAIR_BIT_DRIVER] && irq)
                else $error("enabled driver event lost");

            ch_drv_off_a: assert property (
                !st_q.en[g][LCAIR_BIT_DRIVER]
                |-> !channel_irq_src[g][LCAIR_BIT_DRIVER])
                else $error("masked driver source raised");

            ch_fifo_on_a: assert property (
                st_q.evt[g][1] && st_q.en[g][LCAIR_BIT_FIFO]
                |-> channel_irq_src[g][LCAIR_BIT_FIFO] && irq)
                else $error("enabled fifo event lost");

            ch_fifo_off_a: assert property (
                !st_q.en[g][LCAIR_BIT_FIFO]
                |-> !channel_irq_src[g][LCAIR_BIT_FIFO])
                else $error("masked fifo source raised");

            ch_code_on_a: assert property (
                st_q.evt[g][0] && st_q.en[g][LCAIR_BIT_CODE]
                |-> channel_irq_src[g][LCAIR_BIT_CODE] && irq)
                else $error("enabled code event lost");

            ch_code_off_a: assert property (
                !st_q.en[g][LCAIR_BIT_CODE]
                |-> !channel_irq_src[g][LCAIR_BIT_CODE])
                else $error("masked code source raised");

            ch_loop_off_a: assert property (
                !st_q.en[g][LCAIR_BIT_LOOP]
                |-> !channel_irq_src[g][LCAIR_BIT_LOOP])
                else $error("masked loop source raised");

            ch_ais_on_a: assert property (
                alarm_indication_event[g] && st_q.en[g][LCAIR_BIT_AIS]
                |-> channel_irq_src[g][LCAIR_BIT_AIS])
                else $error("enabled ais source lost");

            ch_los_off_a: assert property (
                !st_q.en[g][LCAIR_BIT_LOS]
                |-> !channel_irq_src[g][LCAIR_BIT_LOS])
                else $error("masked los source raised");

            ch_prbs_on_a: assert property (
                prbs_pattern_event[g] && st_q.en[g][LCAIR_BIT_PRBS]
                |-> channel_irq_src[g][LCAIR_BIT_PRBS])
                else $error("enabled prbs source lost");

            ch_live_a: assert property (
                clk_en
                |=> st_q.live[g] == $past(st_q.s2[g]))
                else $error("live status not following");

            ch_change_a: assert property (
                clk_en && st_q.armed && chg[g] != 3'b000
                |=> (st_q.evt[g] & $past(chg[g])) == $past(chg[g]))
                else $error("status change not captured");

            ch_status_rd_a: assert property (
                rd_any_hit && reg_addr == {1'b0, 3'(g), LCAIR_OFS_STATUS}
                |=> reg_rdata == {1'b0, $past(st_q.live[g]), 4'h0})
                else $error("channel status read wrong");

            ch_clear_a: assert property (
                wr_evt_hit && reg_addr[6:4] == 3'(g) && chg[g] == 3'b000
                |=> (st_q.evt[g] & $past(reg_wdata[6:4])) == 3'b000)
                else $error("event flag not cleared");

            ch_hold_a: assert property (
                !wr_evt_hit
                |=> (st_q.evt[g] & $past(st_q.evt[g])) == $past(st_q.evt[g]))
                else $error("event flag dropped");

            ch_pend_a: assert property (
                |channel_irq_src[g]
                |-> irq)
                else $error("channel source missed interrupt");
        end
    endgenerate

    // ------------------------------------------------------------
    // coverage
    // ------------------------------------------------------------
    irq_cover_c: cover property (!irq ##1 irq);
    clear_cover_c: cover property (irq ##1 clk_en && reg_wr ##1 !irq);
    read_cover_c: cover property (clk_en && reg_rd && reg_addr[3:0] == LCAIR_OFS_STATUS);
    both_cover_c: cover property (st_q.evt[0][2] && st_q.evt[0][0]);
    freeze_cover_c: cover property (!clk_en && reg_wr);

endmodule

`default_nettype wire

// ===== inc/lcair_pkg.sv
/*
 * package for the per-channel alarm interrupt register block: register
 * decode, field positions, reset values and the carrier structs.
 * assumes one clock domain and the plain strobe register port.
 */
// How it works
// - enable bit 6 gates driver-monitor interrupts
// - enable bit 5 gates fifo-limit interrupts
// - enable bit 4 gates code-violation interrupts
// - enable bit 3 gates loop-code interrupts
// - enable bit 2 gates alarm-indication interrupts
// - enable bit 1 gates signal-loss interrupts
// - enable bit 0 gates prbs-pattern interrupts
// - status bit 6 mirrors live driver fault
// - any driver-fault edge raises enabled interrupt
// - status bit 5 mirrors fifo near-limit
// - any fifo-limit edge raises enabled interrupt
// - status bit 4 mirrors live code violation
// - any code-violation edge raises enabled interrupt
package lcair_pkg;

    // ------------------------------------------------------------
    // geometry and decode
    // ------------------------------------------------------------
    localparam int unsigned LCAIR_CHANNELS = 8;
    localparam int unsigned LCAIR_ADDR_W = 8;
    localparam int unsigned LCAIR_CH_LSB = 4;
    localparam int unsigned LCAIR_CH_MSB = 6;
    localparam logic [3:0] LCAIR_OFS_IRQ_EN = 4'h4;
    localparam logic [3:0] LCAIR_OFS_STATUS = 4'h5;
    localparam logic [3:0] LCAIR_OFS_EVENT = 4'h6;
    localparam logic [3:0] LCAIR_OFS_GLOBAL = 4'h7;
    localparam logic [7:0] LCAIR_ADDR_IRQ_SUMMARY = 8'h80;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned LCAIR_BIT_DRIVER = 6;
    localparam int unsigned LCAIR_BIT_FIFO = 5;
    localparam int unsigned LCAIR_BIT_CODE = 4;
    localparam int unsigned LCAIR_BIT_LOOP = 3;
    localparam int unsigned LCAIR_BIT_AIS = 2;
    localparam int unsigned LCAIR_BIT_LOS = 1;
    localparam int unsigned LCAIR_BIT_PRBS = 0;
    localparam logic [7:0] LCAIR_EN_MASK = 8'h7f;
    localparam logic [7:0] LCAIR_EN_RESET = 8'h00;
    localparam logic [7:0] LCAIR_STATUS_RESET = 8'h00;
    localparam logic [7:0] LCAIR_EVENT_MASK = 8'h70;
    localparam logic [7:0] LCAIR_UNMAPPED = 8'h00;
    localparam int unsigned LCAIR_FIFO_NEAR_BITS = 3;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lcair_bus_s;

    typedef struct packed {
        logic driver;
        logic fifo;
        logic code;
    } lcair_alarm_s;

    typedef struct packed {
        logic [LCAIR_CHANNELS-1:0][7:0] en;
        logic [LCAIR_CHANNELS-1:0][2:0] live;
        logic [LCAIR_CHANNELS-1:0][2:0] evt;
        logic [LCAIR_CHANNELS-1:0][2:0] s1;
        logic [LCAIR_CHANNELS-1:0][2:0] s2;
        logic [7:0] rdata;
        logic armed;
    } lcair_state_s;

endpackage

// ===== sim/lcair_regs_test.sv
/*
 * self-checking bench for lcair_regs: reset values, enable read-back,
 * live status, change events, masking and the external request levels.
 * assumes lcair_pkg is compiled first; one 25 MHz clock, no partner model.
 */
`timescale 1ns/1ps
`default_nettype none

module lcair_regs_test
    import lcair_pkg::*;
;
    // ----------------------------------------------------------------
    // stimulus and observation
    // ----------------------------------------------------------------
    logic mclk = 1'b0, resetn = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic rd_pend = 1'b0, irq;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [7:0] exp_q[$], en_v[8];
    logic [7:0] alm[3] = '{default: 8'h00};
    logic [7:0] ext[4] = '{default: 8'h00};
    logic [7:0][6:0] src;
    logic [31:0] seed = 32'd24;
    int miscompares = 0, check_count = 0, c, b;

    always #20 mclk = ~mclk;

    lcair_regs lcair_regs_inst (.mclk(mclk), .resetn(resetn), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .driver_monitor(alm[2]), .fifo_near_limit(alm[1]),
        .code_violation(alm[0]), .loop_code_event(ext[3]), .alarm_indication_event(ext[2]),
        .rx_signal_loss_event(ext[1]), .prbs_pattern_event(ext[0]),
        .channel_irq_src(src), .irq(irq));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // leading edge wait keeps back-to-back strobes from two writes in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask

    task automatic wait_irq(input logic e);
        for (int i = 0; i < 8 && irq !== e; i++) @(negedge mclk);
    endtask

    task automatic summarize;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // read data stand only in the cycle after the strobe
    always @(negedge mclk) begin
        if (rd_pend) check(reg_rdata, exp_q.pop_front());
        rd_pend = reg_rd;
    end

    initial begin
        #2_000_000;
        miscompares++;
        summarize;
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        for (c = 0; c < 8; c++) begin
            rd(8'(16 * c + 4), LCAIR_EN_RESET);
            rd(8'(16 * c + 5), LCAIR_STATUS_RESET);
        end
        repeat (3) begin
            for (int k = 0; k < 3; k++) alm[k] <= 8'(xs());
            repeat (5) @(posedge mclk);
            for (c = 0; c < 8; c++) rd(8'(16 * c + 5), {1'b0, alm[2][c], alm[1][c], alm[0][c], 4'h0});
        end
        for (int k = 0; k < 3; k++) alm[k] <= 8'h00;
        repeat (5) @(posedge mclk);
        for (c = 0; c < 8; c++) wr(8'(16 * c + 6), LCAIR_EVENT_MASK);
        for (c = 0; c < 8; c++) begin
            en_v[c] = 8'(xs());
            wr(8'(16 * c + 4), en_v[c]);
        end
        // a strobe while frozen must be ignored
        clk_en <= 1'b0;
        wr(8'h04, 8'hff);
        clk_en <= 1'b1;
        rd(8'h0f, LCAIR_UNMAPPED);
        for (c = 0; c < 8; c++) rd(8'(16 * c + 4), en_v[c] & LCAIR_EN_MASK);
        for (c = 0; c < 8; c++) wr(8'(16 * c + 4), 8'h00);
        for (int k = 0; k < 3; k++) begin
            c = int'(xs() % 8);
            b = 4 + k;
            wr(8'(16 * c + 4), 8'(1 << b));
            repeat (2) begin
                alm[k][c] <= ~alm[k][c];
                wait_irq(1'b1);
                check({7'h00, irq}, 8'h01);
                check({1'b0, src[c]}, 8'(1 << b));
                rd(8'(16 * c + 6), 8'(1 << b));
                check({7'h00, irq}, 8'h01);
                wr(8'(16 * c + 6), 8'(1 << b));
                wait_irq(1'b0);
                check({7'h00, irq}, 8'h00);
            end
            wr(8'(16 * c + 4), 8'h00);
            alm[k][c] <= ~alm[k][c];
            repeat (6) @(negedge mclk);
            check({7'h00, irq}, 8'h00);
            rd(8'(16 * c + 6), 8'(1 << b));
            wr(8'(16 * c + 6), 8'(1 << b));
        end
        for (b = 0; b < 4; b++) begin
            c = int'(xs() % 8);
            wr(8'(16 * c + 4), 8'(1 << b));
            ext[b][c] <= 1'b1;
            wait_irq(1'b1);
            check({1'b0, src[c]}, 8'(1 << b));
            rd(LCAIR_ADDR_IRQ_SUMMARY, 8'(1 << c));
            rd(8'(16 * c + 7), 8'h01);
            wr(8'(16 * c + 4), 8'h00);
            wait_irq(1'b0);
            check({7'h00, irq}, 8'h00);
            ext[b][c] <= 1'b0;
        end
        repeat (2) @(posedge mclk);
        summarize;
    end
endmodule

`default_nettype wire
